// ### common/dbgcs_pkg.sv
// Package with register map, field layout and types of the debug sequencer.
package dbgcs_pkg;

  // --------------------------------------------------------------------------
  // Register byte addresses
  // --------------------------------------------------------------------------
  localparam logic [11:0] DBGCS_ADDR_CTRL1 = 12'h0100;
  localparam logic [11:0] DBGCS_ADDR_STATUS = 12'h0104;
  localparam logic [11:0] DBGCS_ADDR_CMPA_CTL = 12'h0110;
  localparam logic [11:0] DBGCS_ADDR_CMPA_ADR = 12'h0114;
  localparam logic [11:0] DBGCS_ADDR_CMPA_DAT = 12'h0118;
  localparam logic [11:0] DBGCS_ADDR_CMPB_CTL = 12'h0120;
  localparam logic [11:0] DBGCS_ADDR_CMPB_ADR = 12'h0124;
  localparam logic [11:0] DBGCS_ADDR_CMPD_CTL = 12'h0130;
  localparam logic [11:0] DBGCS_ADDR_CMPD_ADR = 12'h0134;
  localparam logic [11:0] DBGCS_ADDR_STATE1 = 12'h0140;
  localparam logic [11:0] DBGCS_ADDR_STATE2 = 12'h0144;
  localparam logic [11:0] DBGCS_ADDR_STATE3 = 12'h0148;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int DBGCS_CTL_DATA_SENSE = 6;
  localparam int DBGCS_CTL_PC_SEL = 5;
  localparam int DBGCS_CTL_DIR_VAL = 3;
  localparam int DBGCS_CTL_DIR_EN = 2;
  localparam int DBGCS_CTL_ON = 0;
  localparam int DBGCS_C1_ARM = 7;
  localparam int DBGCS_C1_BRK_EN = 4;
  localparam int DBGCS_C1_FORCE = 6;
  localparam int DBGCS_C1_EEV_LO = 2;

  // --------------------------------------------------------------------------
  // Reset values and encodings
  // --------------------------------------------------------------------------
  localparam logic [7:0] DBGCS_CTL_RESET = 8'h00;
  localparam logic [23:0] DBGCS_ADR_RESET = 24'h00_0000;
  localparam logic [31:0] DBGCS_DAT_RESET = 32'h0000_0000;
  localparam logic [1:0] DBGCS_EEV_EVENT = 2'b10;
  localparam logic [1:0] DBGCS_RESP_OKAY = 2'b00;
  localparam logic [1:0] DBGCS_RESP_SLVERR = 2'b10;
  localparam logic [1:0] DBGCS_RESP_DECERR = 2'b11;

  // Gray-coded along State0, State1, State2, State3, Final.
  typedef enum logic [2:0] {
    DBGCS_ST0 = 3'b000,
    DBGCS_ST1 = 3'b001,
    DBGCS_ST2 = 3'b011,
    DBGCS_ST3 = 3'b010,
    DBGCS_STF = 3'b110
  } dbgcs_state_t;

  // Reported state flag codes.
  localparam logic [2:0] DBGCS_FLAG_ST0 = 3'b000;
  localparam logic [2:0] DBGCS_FLAG_ST1 = 3'b001;
  localparam logic [2:0] DBGCS_FLAG_ST2 = 3'b010;
  localparam logic [2:0] DBGCS_FLAG_ST3 = 3'b011;
  localparam logic [2:0] DBGCS_FLAG_FINAL = 3'b100;

  // One core bus access as seen by the comparators.
  typedef struct packed {
    logic valid;
    logic is_pc;
    logic read;
    logic [23:0] addr;
    logic [31:0] data;
  } dbgcs_access_t;

  // Comparator configuration.
  typedef struct packed {
    logic [7:0] ctl;
    logic [23:0] addr;
    logic [31:0] data;
  } dbgcs_cmp_cfg_t;

endpackage

// ### src/dbgcs_comparator.sv
// Single address comparator with data and direction qualification.
`timescale 1ns/10ps
module dbgcs_comparator
  import dbgcs_pkg::*;
#(
  parameter bit HAS_DATA = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dbgcs_cmp_cfg_t cfg,
  input wire dbgcs_access_t acc,
  output logic match_reg
);

  logic pc_mode;
  logic src_ok;
  logic addr_ok;
  logic dir_ok;
  logic data_ok;
  logic match_next;

  always_comb begin
    pc_mode = cfg.ctl[DBGCS_CTL_PC_SEL];
    src_ok = (acc.is_pc == pc_mode); // RL4
    addr_ok = (acc.addr == cfg.addr); // RL7
    // Direction matters only for data accesses with qualification on.
    if (pc_mode || !cfg.ctl[DBGCS_CTL_DIR_EN]) begin
      dir_ok = 1'b1; // RL5
    end else begin
      dir_ok = (acc.read == cfg.ctl[DBGCS_CTL_DIR_VAL]); // RL5
    end
    if (!HAS_DATA || pc_mode) begin
      data_ok = 1'b1; // RL3
    end else begin
      data_ok = (acc.data == cfg.data) ^ cfg.ctl[DBGCS_CTL_DATA_SENSE]; // RL3
    end
    match_next = cfg.ctl[DBGCS_CTL_ON] && acc.valid && src_ok && addr_ok &&
                 dir_ok && data_ok; // RL6
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= match_next;
    end
  end

endmodule // dbgcs_comparator

// ### src/dbgcs_top.sv
// Debug comparators, event arbiter, state sequencer and AXI4-Lite registers.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps

// Operation
// (RL1) State flags: 000..100, 101-111 reserved
// (RL2) Comparator registers writable only while disarmed
// (RL3) Data sense bit 6: equal or differ
// (RL4) Bit 5 selects data or PC addresses
// (RL5) Optional read/write qualification, ignored for PC
// (RL6) Bit 0 enables the comparator
// (RL7) Comparator B holds full 24-bit address
// (RL8) Priority: force, external, match3, match1, match0
// (RL9) Arm bit moves State0 to State1
// (RL10) Final State only returns to State0
// (RL11) States one to three freely interconnected
// (RL12) Each transition updates the state flags
// (RL13) Event return to State0 requests breakpoint
// (RL14) Software disarm gives no breakpoint request
// (RL15) Final returns at once, disarms, breaks
module dbgcs_top
  import dbgcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dbgcs_access_t core_access,
  input wire logic external_event_input,
  output logic breakpoint_req_reg,
  output logic armed_reg
);

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  dbgcs_cmp_cfg_t cmp_cfg_reg [3];
  logic brk_en_reg;
  logic [1:0] ext_event_mode_reg;
  logic [7:0] state_ctl_reg [3];
  logic force_final_request;
  logic disarm_write;
  dbgcs_state_t state_reg;
  dbgcs_state_t state_next;
  logic [2:0] state_flags;
  logic event_brk;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  logic [11:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic wr_fire;
  logic [1:0] wr_resp;

  function automatic logic [31:0] apply_strobe(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Index of comparator and field (0 ctl, 1 addr, 2 data); all ones: unmapped.
  function automatic logic [3:0] cmp_decode(input logic [11:0] a);
    logic [3:0] r;
    r = 4'hF;
    if (a == DBGCS_ADDR_CMPA_CTL) begin
      r = 4'h0;
    end else if (a == DBGCS_ADDR_CMPA_ADR) begin
      r = 4'h1;
    end else if (a == DBGCS_ADDR_CMPA_DAT) begin
      r = 4'h2;
    end else if (a == DBGCS_ADDR_CMPB_CTL) begin
      r = 4'h4;
    end else if (a == DBGCS_ADDR_CMPB_ADR) begin
      r = 4'h5;
    end else if (a == DBGCS_ADDR_CMPD_CTL) begin
      r = 4'h8;
    end else if (a == DBGCS_ADDR_CMPD_ADR) begin
      r = 4'h9;
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) &&
                       !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) &&
                      !s_axi_bvalid;
    end
  end

  // Decode of the write and its response.
  logic [3:0] wr_sel;
  always_comb begin
    wr_sel = cmp_decode(awaddr_reg);
    wr_resp = DBGCS_RESP_OKAY;
    if (wr_sel != 4'hF) begin
      if (armed_reg) begin
        wr_resp = DBGCS_RESP_SLVERR; // RL2
      end
    end else if (awaddr_reg != DBGCS_ADDR_CTRL1 &&
                 awaddr_reg != DBGCS_ADDR_STATUS &&
                 awaddr_reg != DBGCS_ADDR_STATE1 &&
                 awaddr_reg != DBGCS_ADDR_STATE2 &&
                 awaddr_reg != DBGCS_ADDR_STATE3) begin
      wr_resp = DBGCS_RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DBGCS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_resp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Comparator configuration
  // --------------------------------------------------------------------------
  generate
    for (genvar c = 0; c < 3; c++) begin : g_cfg
      logic [31:0] ctl_new;
      logic [31:0] adr_new;
      logic [31:0] dat_new;
      assign ctl_new = apply_strobe({24'h00_0000, cmp_cfg_reg[c].ctl},
                                    wdata_reg, wstrb_reg);
      assign adr_new = apply_strobe({8'h00, cmp_cfg_reg[c].addr},
                                    wdata_reg, wstrb_reg);
      assign dat_new = apply_strobe(cmp_cfg_reg[c].data, wdata_reg,
                                    wstrb_reg);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cmp_cfg_reg[c] <= '{DBGCS_CTL_RESET, DBGCS_ADR_RESET,
                              DBGCS_DAT_RESET};
        end else if (wr_fire && !armed_reg &&
                     wr_sel[3:2] == 2'(c)) begin // RL2
          case (wr_sel[1:0])
            2'd0: cmp_cfg_reg[c].ctl <= ctl_new[7:0];
            2'd1: cmp_cfg_reg[c].addr <= adr_new[23:0]; // RL7
            default: cmp_cfg_reg[c].data <= dat_new;
          endcase
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Control register one and state control registers
  // --------------------------------------------------------------------------
  logic [31:0] c1_val;
  always_comb begin
    c1_val = apply_strobe({24'h00_0000, armed_reg, 1'b0, 1'b0, brk_en_reg,
                           ext_event_mode_reg, 2'b00}, wdata_reg, wstrb_reg);
    force_final_request = armed_reg && wr_fire &&
                          awaddr_reg == DBGCS_ADDR_CTRL1 &&
                          c1_val[DBGCS_C1_FORCE];
    disarm_write = armed_reg && wr_fire && awaddr_reg == DBGCS_ADDR_CTRL1 &&
                   !c1_val[DBGCS_C1_ARM];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brk_en_reg <= 1'b0;
      ext_event_mode_reg <= 2'b00;
    end else if (wr_fire && awaddr_reg == DBGCS_ADDR_CTRL1) begin
      brk_en_reg <= c1_val[DBGCS_C1_BRK_EN];
      ext_event_mode_reg <= c1_val[DBGCS_C1_EEV_LO +: 2];
    end
  end

  generate
    for (genvar s = 0; s < 3; s++) begin : g_sctl
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          state_ctl_reg[s] <= DBGCS_CTL_RESET;
        end else if (wr_fire && awaddr_reg ==
                     DBGCS_ADDR_STATE1 + 12'(4 * s)) begin
          state_ctl_reg[s] <= wdata_reg[7:0];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Comparators and external event synchroniser
  // --------------------------------------------------------------------------
  logic [2:0] match;
  generate
    for (genvar c = 0; c < 3; c++) begin : g_cmp
      dbgcs_comparator #(
        .HAS_DATA(c == 0)
      ) u_cmp (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cmp_cfg_reg[c]),
        .acc(core_access),
        .match_reg(match[c])
      );
    end
  endgenerate

  logic [2:0] eev_sync_reg;
  logic eev_level_reg;
  logic eev_pulse;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eev_sync_reg <= 3'b000;
      eev_level_reg <= 1'b0;
    end else begin
      eev_sync_reg <= {eev_sync_reg[1:0], external_event_input};
      if (eev_sync_reg[2] == eev_sync_reg[1]) begin
        eev_level_reg <= eev_sync_reg[2];
      end
    end
  end
  assign eev_pulse = eev_sync_reg[2] && eev_sync_reg[1] && !eev_level_reg &&
                     ext_event_mode_reg == DBGCS_EEV_EVENT;

  // --------------------------------------------------------------------------
  // Event arbiter and state sequencer
  // --------------------------------------------------------------------------
  // State control byte: bits [1:0] target on match0, [3:2] on match1,
  // [5:4] on match3, [7:6] on external event; 0 means State0, 1..3 the
  // numbered state.
  function automatic dbgcs_state_t target(input logic [1:0] code);
    dbgcs_state_t t;
    case (code)
      2'd0: t = DBGCS_ST0;
      2'd1: t = DBGCS_ST1;
      2'd2: t = DBGCS_ST2;
      default: t = DBGCS_ST3;
    endcase
    return t;
  endfunction

  logic [7:0] cur_ctl;
  always_comb begin
    state_next = state_reg;
    event_brk = 1'b0;
    cur_ctl = 8'h00;
    case (state_reg)
      DBGCS_ST1: cur_ctl = state_ctl_reg[0];
      DBGCS_ST2: cur_ctl = state_ctl_reg[1];
      DBGCS_ST3: cur_ctl = state_ctl_reg[2];
      default: cur_ctl = 8'h00;
    endcase
    case (state_reg)
      DBGCS_ST0: begin
        if (wr_fire && awaddr_reg == DBGCS_ADDR_CTRL1 &&
            c1_val[DBGCS_C1_ARM]) begin
          state_next = DBGCS_ST1; // RL9
        end
      end
      DBGCS_STF: begin
        state_next = DBGCS_ST0; // RL10 RL15
        event_brk = 1'b1; // RL15
      end
      default: begin
        if (force_final_request) begin
          state_next = DBGCS_STF; // RL8
        end else if (disarm_write) begin
          state_next = DBGCS_ST0; // RL14
        end else if (eev_pulse) begin
          state_next = target(cur_ctl[7:6]); // RL8 RL11
        end else if (match[2]) begin
          state_next = target(cur_ctl[5:4]); // RL8 RL11
        end else if (match[1]) begin
          state_next = target(cur_ctl[3:2]); // RL8 RL11
        end else if (match[0]) begin
          state_next = target(cur_ctl[1:0]); // RL8 RL11
        end
        if (state_next == DBGCS_ST0 && !disarm_write) begin
          event_brk = 1'b1; // RL13
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= DBGCS_ST0;
      armed_reg <= 1'b0;
      breakpoint_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next; // RL12
      armed_reg <= state_next != DBGCS_ST0; // RL15
      breakpoint_req_reg <= event_brk && brk_en_reg; // RL13 RL14
    end
  end

  always_comb begin
    case (state_reg)
      DBGCS_ST1: state_flags = DBGCS_FLAG_ST1; // RL1
      DBGCS_ST2: state_flags = DBGCS_FLAG_ST2; // RL1
      DBGCS_ST3: state_flags = DBGCS_FLAG_ST3; // RL1
      DBGCS_STF: state_flags = DBGCS_FLAG_FINAL; // RL1
      default: state_flags = DBGCS_FLAG_ST0; // RL1
    endcase
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  logic [31:0] rd_val;
  logic [1:0] rd_resp;
  logic [3:0] rd_sel;
  always_comb begin
    rd_sel = cmp_decode(s_axi_araddr);
    rd_val = 32'h0000_0000;
    rd_resp = DBGCS_RESP_OKAY;
    if (rd_sel != 4'hF) begin
      case (rd_sel[1:0])
        2'd0: rd_val = {24'h00_0000, cmp_cfg_reg[rd_sel[3:2]].ctl};
        2'd1: rd_val = {8'h00, cmp_cfg_reg[rd_sel[3:2]].addr};
        default: rd_val = cmp_cfg_reg[rd_sel[3:2]].data;
      endcase
    end else if (s_axi_araddr == DBGCS_ADDR_CTRL1) begin
      rd_val = {24'h00_0000, armed_reg, 1'b0, 1'b0, brk_en_reg,
                ext_event_mode_reg, 2'b00};
    end else if (s_axi_araddr == DBGCS_ADDR_STATUS) begin
      rd_val = {29'h0000_0000, state_flags}; // RL1
    end else if (s_axi_araddr == DBGCS_ADDR_STATE1) begin
      rd_val = {24'h00_0000, state_ctl_reg[0]};
    end else if (s_axi_araddr == DBGCS_ADDR_STATE2) begin
      rd_val = {24'h00_0000, state_ctl_reg[1]};
    end else if (s_axi_araddr == DBGCS_ADDR_STATE3) begin
      rd_val = {24'h00_0000, state_ctl_reg[2]};
    end else begin
      rd_resp = DBGCS_RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= DBGCS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_resp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // dbgcs_top

// ### testbench/dbgcs_core_model.sv
// Behavioural model of the core bus that feeds the comparators.
`timescale 1ns/10ps
module dbgcs_core_model
  import dbgcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic send,
  input wire dbgcs_access_t req,
  output dbgcs_access_t core_access
);
  // Between accesses the address and data lines toggle, so no stale match.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_access <= '0;
    end else if (send) begin
      core_access <= req;
    end else begin
      core_access.valid <= 1'b0;
      core_access.addr <= ~core_access.addr;
      core_access.data <= ~core_access.data;
    end
  end
endmodule // dbgcs_core_model

// ### testbench/dbgcs_properties.sv
// Concurrent checks on the ports of the debug sequencer top.
`timescale 1ns/10ps
module dbgcs_properties
  import dbgcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic breakpoint_req_reg,
  input wire logic armed_reg
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bp_pulse_a: assert property (breakpoint_req_reg |=>
    !breakpoint_req_reg)
    else $error("breakpoint request longer than one cycle");
  bp_cause_a: assert property (breakpoint_req_reg |->
    $past(armed_reg) || $past(armed_reg, 2))
    else $error("breakpoint request without an armed sequencer");
  bp_disarmed_a: assert property (breakpoint_req_reg |-> !armed_reg)
    else $error("still armed at breakpoint request");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |->
    ##[1:2] s_axi_rvalid)
    else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  busy_ready_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");

  cover property ($rose(armed_reg));
  cover property (breakpoint_req_reg);
  cover property (s_axi_bvalid && s_axi_bresp == DBGCS_RESP_SLVERR);
endmodule // dbgcs_properties

bind dbgcs_top dbgcs_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .breakpoint_req_reg(breakpoint_req_reg), .armed_reg(armed_reg));

// ### testbench/dbgcs_top_tb.sv
// Self-checking testbench of the debug sequencer top.
`timescale 1ns/10ps
module dbgcs_top_tb;
  import dbgcs_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, send = 0, eev = 0;
  logic awready, wready, bvalid, arready, rvalid, bp, armed;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp;
  dbgcs_access_t req = '0, acc;
  logic [31:0] lfsr_q = 32'h0000_ba76;
  int n_errors = 0, num_checks = 0, n_bp = 0, cyc = 0;

  dbgcs_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_access(acc),
    .external_event_input(eev), .breakpoint_req_reg(bp),
    .armed_reg(armed));
  dbgcs_core_model u_core (.aclk(aclk), .aresetn(aresetn), .send(send),
    .req(req), .core_access(acc));

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (bp === 1'b1) n_bp++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test;
    end
  end

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction

  // Expected match of comparator A for one access.
  function automatic bit exp_hit(logic [7:0] c, dbgcs_access_t a,
                                 logic [23:0] ca, logic [31:0] cd);
    if (!c[0] || a.addr != ca) return 0;
    if (c[5]) return a.is_pc;
    if (a.is_pc || (c[2] && a.read != c[3])) return 0;
    return c[6] ? (a.data != cd) : (a.data == cd);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1;
    end
    bready <= 0;
    chk(bresp, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1;
    end
    rready <= 0;
    chk(rdata, ed);
    chk(rresp, er);
  endtask

  task automatic go(input dbgcs_access_t a);
    req <= a;
    send <= 1;
    @(posedge aclk);
    send <= 0;
    repeat (6) @(posedge aclk);
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    logic [7:0] c;
    logic [23:0] ca;
    logic [31:0] cd, r;
    dbgcs_access_t a;
    bit hit;
    int b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(DBGCS_ADDR_CMPA_CTL, 0, DBGCS_RESP_OKAY);
    rd(DBGCS_ADDR_STATUS, DBGCS_FLAG_ST0, DBGCS_RESP_OKAY);
    rd(12'h0ffc, 0, DBGCS_RESP_DECERR);
    wr(12'h0ffc, 0, DBGCS_RESP_DECERR);
    wr(DBGCS_ADDR_STATE1, 0, DBGCS_RESP_OKAY);
    $display("test reset done");
    // ----------------------------------------------------------------
    // Comparator qualification, one armed access per round
    // ----------------------------------------------------------------
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      c = 8'(rnd()) & 8'h6d;
      c[0] = (i != 0);
      ca = 24'(rnd());
      cd = rnd();
      a = '0;
      a.valid = 1;
      a.is_pc = r[4] ? c[5] : r[0];
      a.read = r[1];
      a.addr = r[2] ? ca : ca ^ 24'h00_0001;
      a.data = r[3] ? cd : ~cd;
      hit = exp_hit(c, a, ca, cd);
      wr(DBGCS_ADDR_CMPA_CTL, {24'h00_0000, c}, DBGCS_RESP_OKAY);
      wr(DBGCS_ADDR_CMPA_ADR, {8'h00, ca}, DBGCS_RESP_OKAY);
      wr(DBGCS_ADDR_CMPA_DAT, cd, DBGCS_RESP_OKAY);
      wr(DBGCS_ADDR_CTRL1, 32'h0000_0090, DBGCS_RESP_OKAY);
      b0 = n_bp;
      go(a);
      chk(n_bp - b0, hit);
      chk(armed, !hit);
      wr(DBGCS_ADDR_CTRL1, 32'h0000_0010, DBGCS_RESP_OKAY);
      chk(n_bp - b0, hit);
      chk(armed, 0);
    end
    ca = 24'(rnd());
    wr(DBGCS_ADDR_CMPB_ADR, {8'h00, ca}, DBGCS_RESP_OKAY);
    rd(DBGCS_ADDR_CMPB_ADR, {8'h00, ca}, DBGCS_RESP_OKAY);
    $display("test compare done");
    // ----------------------------------------------------------------
    // Walk State1, State3, State2 and back to State0
    // ----------------------------------------------------------------
    wr(DBGCS_ADDR_CMPA_CTL, 32'h0000_0021, DBGCS_RESP_OKAY);
    wr(DBGCS_ADDR_CMPA_ADR, {8'h00, ca}, DBGCS_RESP_OKAY);
    wr(DBGCS_ADDR_STATE1, 32'h0000_0003, DBGCS_RESP_OKAY);
    wr(DBGCS_ADDR_STATE3, 32'h0000_0002, DBGCS_RESP_OKAY);
    wr(DBGCS_ADDR_STATE2, 0, DBGCS_RESP_OKAY);
    wr(DBGCS_ADDR_CTRL1, 32'h0000_0090, DBGCS_RESP_OKAY);
    rd(DBGCS_ADDR_STATUS, DBGCS_FLAG_ST1, DBGCS_RESP_OKAY);
    wr(DBGCS_ADDR_CMPA_CTL, 0, DBGCS_RESP_SLVERR);
    rd(DBGCS_ADDR_CMPA_CTL, 32'h0000_0021, DBGCS_RESP_OKAY);
    a = '0;
    a.valid = 1;
    a.is_pc = 1;
    a.addr = ca;
    b0 = n_bp;
    go(a);
    rd(DBGCS_ADDR_STATUS, DBGCS_FLAG_ST3, DBGCS_RESP_OKAY);
    go(a);
    rd(DBGCS_ADDR_STATUS, DBGCS_FLAG_ST2, DBGCS_RESP_OKAY);
    go(a);
    chk(n_bp - b0, 1);
    rd(DBGCS_ADDR_STATUS, DBGCS_FLAG_ST0, DBGCS_RESP_OKAY);
    wr(DBGCS_ADDR_CMPB_CTL, 32'h0000_0021, DBGCS_RESP_OKAY);
    wr(DBGCS_ADDR_STATE1, 32'h0000_0083, DBGCS_RESP_OKAY);
    wr(DBGCS_ADDR_CTRL1, 32'h0000_0098, DBGCS_RESP_OKAY);
    eev <= 1;
    @(posedge aclk);
    go(a);
    rd(DBGCS_ADDR_STATUS, DBGCS_FLAG_ST2, DBGCS_RESP_OKAY);
    $display("test sequence done");
    // ----------------------------------------------------------------
    // Forced final state with breakpoints off and on
    // ----------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      b0 = n_bp;
      wr(DBGCS_ADDR_CTRL1, 32'h0000_0080 | (i << 4), DBGCS_RESP_OKAY);
      wr(DBGCS_ADDR_CTRL1, 32'h0000_00c0 | (i << 4), DBGCS_RESP_OKAY);
      repeat (6) @(posedge aclk);
      chk(n_bp - b0, i);
      chk(armed, 0);
      rd(DBGCS_ADDR_STATUS, DBGCS_FLAG_ST0, DBGCS_RESP_OKAY);
    end
    $display("test force done");
    end_of_test;
  end
endmodule // dbgcs_top_tb
